// file: shared/biu_consts.svh
// Purpose: constants for the data access path of the bus interface unit
// Assumes: one clock, synchronous active-low reset
// Notes:   widths of the internal buses and size encodings
`ifndef BIU_CONSTS_SVH
`define BIU_CONSTS_SVH
`define BIU_ADDR_W      24
`define BIU_CODE_W      32
`define BIU_DATA_W      16
`define BIU_BUF_W       32
`define BIU_SZ_BYTE     2'h0
`define BIU_SZ_WORD     2'h1
`define BIU_SZ_DWORD    2'h2
`endif

// file: shared/biu_pkg.sv
// Purpose: types for the data access path of the bus interface unit
// Assumes: constants come from biu_consts.svh
// Notes:   request from the core travels as one packed struct
`include "biu_consts.svh"
package biu_pkg;
    typedef struct packed {
        logic                    wr;
        logic [1:0]              size;
        logic [`BIU_ADDR_W-1:0]  addr;
        logic [`BIU_BUF_W-1:0]   wdata;
    } biu_req_t;
    typedef struct packed {
        logic even;
        logic quad;
        logic oct;
    } biu_align_t;
endpackage : biu_pkg

// file: hdl/biu_data_path.sv
// Purpose: data read/write path between the core link and internal buses
// Assumes: memory answers each bus cycle with mem_rdy_i, same clock
// Notes:   one 16-bit data bus cycle per half word, except a memory double read (one code-bus cycle); byte cycles single
// Operation
// (RULE1) core loads target address into data address register before any read
// (RULE2) unit fetches the value over internal buses into the data buffer
// (RULE3) buffered read data is forwarded to the core, ending the read
// (RULE4) core loads destination address into data address register before write
// (RULE5) write value from the core goes into the data buffer first
// (RULE6) buffered write data is stored at the held address by a bus cycle
// (RULE7) address, code, data buses and strobes sequenced as one bus cycle
// (RULE8) byte, word and double-word accesses use distinct cycle patterns
// (RULE9) prefetch address classed even, 4-byte and 8-byte by low three bits
// (RULE10) data buffer is 32 bits, holding read and write data
// (RULE11) memory uses code and data buses; peripherals only the data bus
// (RULE12) byte read from even address returns only the lower lane
`timescale 1ns/1ps
`include "biu_consts.svh"
module biu_data_path (
    input  wire logic                    mclk_i,
    input  wire logic                    reset_n_i,
    input  wire logic                    req_valid_i,
    input  wire biu_pkg::biu_req_t       req_i,
    output logic                         req_ready_o,
    output logic                         rsp_valid_o,
    output logic [`BIU_BUF_W-1:0]        rsp_data_o,
    output logic [`BIU_ADDR_W-1:0]       bus_addr_o,
    output logic                         bus_rd_o,
    output logic                         bus_wr_o,
    output logic [1:0]                   bus_lane_o,
    output logic                         bus_code_sel_o,
    output logic [`BIU_DATA_W-1:0]       internal_data_lines_o,
    input  wire logic [`BIU_DATA_W-1:0]  internal_data_lines_i,
    input  wire logic [`BIU_CODE_W-1:0]  code_bus_i,
    input  wire logic                    mem_sel_i,
    input  wire logic                    mem_rdy_i,
    input  wire logic [`BIU_ADDR_W-1:0]  pf_addr_i,
    output biu_pkg::biu_align_t          pf_class_o
);
    typedef enum logic [1:0] {BIU_IDLE, BIU_CYC, BIU_RSP} biu_st_t;
    biu_st_t                 st_r;
    logic [`BIU_ADDR_W-1:0]  dar_r;     // data address register
    logic [`BIU_BUF_W-1:0]   dbuf_r;    // data buffer
    logic                    wr_r;
    logic [1:0]              size_r;
    logic                    half_r;    // second half-word of a double word
    logic                    take;
    logic                    last;

    assign req_ready_o = (st_r == BIU_IDLE);
    assign take        = req_valid_i && req_ready_o;
    // a memory double-word read ends after its single code-bus beat
    assign last        = (size_r != `BIU_SZ_DWORD) || half_r || (!wr_r && mem_sel_i); // RULE11
    assign rsp_valid_o = (st_r == BIU_RSP);

    // sequencer: idle -> bus cycles -> answer
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            st_r   <= BIU_IDLE;
            half_r <= 1'b0;
        end else begin
            unique case (st_r)
                BIU_IDLE: begin
                    half_r <= 1'b0;
                    if (take) st_r <= BIU_CYC; // RULE1 RULE4
                end
                BIU_CYC: if (mem_rdy_i) begin
                    half_r <= 1'b1;
                    if (last) st_r <= BIU_RSP; // RULE8
                end
                BIU_RSP: st_r <= BIU_IDLE; // RULE3
                default: st_r <= BIU_IDLE;
            endcase
        end
    end

    // address register and size latch
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            dar_r  <= '0;
            wr_r   <= 1'b0;
            size_r <= `BIU_SZ_BYTE;
        end else if (take) begin
            dar_r  <= req_i.addr; // RULE1 RULE4
            wr_r   <= req_i.wr;
            size_r <= req_i.size;
        end
    end

    // data buffer: write data from core, read data from the buses
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            dbuf_r <= '0;
        end else if (take) begin
            dbuf_r <= req_i.wr ? req_i.wdata : '0; // RULE5 RULE10
        end else if (st_r == BIU_CYC && mem_rdy_i && !wr_r) begin
            if (mem_sel_i && size_r == `BIU_SZ_DWORD)
                dbuf_r <= code_bus_i; // RULE11
            else if (size_r == `BIU_SZ_BYTE)
                dbuf_r <= {24'h00_0000, internal_data_lines_i[7:0]}; // RULE12
            else if (half_r)
                dbuf_r[31:16] <= internal_data_lines_i; // RULE2
            else
                dbuf_r[15:0] <= internal_data_lines_i; // RULE2
        end
    end

    // bus cycle drive; memory double reads finish in one code-bus cycle
    always_comb begin
        bus_rd_o              = (st_r == BIU_CYC) && !wr_r; // RULE7
        bus_wr_o              = (st_r == BIU_CYC) && wr_r;  // RULE6
        bus_code_sel_o        = bus_rd_o && mem_sel_i && (size_r == `BIU_SZ_DWORD); // RULE11
        bus_addr_o            = half_r ? dar_r + 24'h00_0002 : dar_r; // RULE7
        bus_lane_o            = (size_r == `BIU_SZ_BYTE) ? 2'h1 : 2'h3; // RULE8
        internal_data_lines_o = half_r ? dbuf_r[31:16] : dbuf_r[15:0]; // RULE6
        if (size_r == `BIU_SZ_BYTE) internal_data_lines_o[15:8] = 8'h00;
    end

    assign rsp_data_o = dbuf_r; // RULE3

    // prefetch alignment classification
    always_comb begin
        pf_class_o.even = ~pf_addr_i[0]; // RULE9
        pf_class_o.quad = ~|pf_addr_i[1:0];
        pf_class_o.oct  = ~|pf_addr_i[2:0];
    end

    property p_rsp_after_cyc;
        @(posedge mclk_i) disable iff (!reset_n_i)
        rsp_valid_o |-> $past(st_r) == BIU_CYC && $past(mem_rdy_i);
    endproperty
    a_rsp_after_cyc: assert property (p_rsp_after_cyc) else $error("answer without cycle"); // RULE3

    property p_take_starts;
        @(posedge mclk_i) disable iff (!reset_n_i)
        take |=> st_r == BIU_CYC && dar_r == $past(req_i.addr);
    endproperty
    a_take_starts: assert property (p_take_starts) else $error("address not loaded"); // RULE1

    property p_wbuf;
        @(posedge mclk_i) disable iff (!reset_n_i)
        take && req_i.wr |=> dbuf_r == $past(req_i.wdata);
    endproperty
    a_wbuf: assert property (p_wbuf) else $error("write buffer wrong"); // RULE5

    property p_wr_strobe;
        @(posedge mclk_i) disable iff (!reset_n_i)
        bus_wr_o |-> !bus_rd_o && (half_r || bus_addr_o == dar_r);
    endproperty
    a_wr_strobe: assert property (p_wr_strobe) else $error("write cycle bad"); // RULE6

    property p_one_cycle;
        @(posedge mclk_i) disable iff (!reset_n_i)
        take |=> (bus_rd_o || bus_wr_o) && !(bus_rd_o && bus_wr_o);
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("no bus cycle"); // RULE7

    property p_byte_lane;
        @(posedge mclk_i) disable iff (!reset_n_i)
        st_r == BIU_CYC && size_r == `BIU_SZ_BYTE |->
            bus_lane_o == 2'h1 && (!bus_wr_o || internal_data_lines_o[15:8] == 8'h00);
    endproperty
    a_byte_lane: assert property (p_byte_lane) else $error("byte lane wrong"); // RULE8

    property p_byte_read;
        @(posedge mclk_i) disable iff (!reset_n_i)
        rsp_valid_o && !wr_r && size_r == `BIU_SZ_BYTE |-> rsp_data_o[31:8] == 24'h00_0000;
    endproperty
    a_byte_read: assert property (p_byte_read) else $error("upper lanes leaked"); // RULE12

    property p_class;
        @(posedge mclk_i) disable iff (!reset_n_i)
        pf_class_o.oct |-> pf_class_o.quad && pf_class_o.even && pf_addr_i[2:0] == 3'h0;
    endproperty
    a_class: assert property (p_class) else $error("class wrong"); // RULE9

    property p_code_mem;
        @(posedge mclk_i) disable iff (!reset_n_i)
        bus_code_sel_o |-> mem_sel_i && bus_rd_o && size_r == `BIU_SZ_DWORD && !half_r;
    endproperty
    a_code_mem: assert property (p_code_mem) else $error("code bus to peripheral"); // RULE11

    property p_reset_idle;
        @(posedge mclk_i)
        !reset_n_i |=> req_ready_o && !rsp_valid_o && !bus_rd_o && !bus_wr_o;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset"); // RULE7

    property p_rd_hold;
        @(posedge mclk_i) disable iff (!reset_n_i)
        bus_rd_o && !mem_rdy_i |=> bus_rd_o && $stable(bus_addr_o);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read cycle dropped early"); // RULE7

    property p_wr_hold;
        @(posedge mclk_i) disable iff (!reset_n_i)
        bus_wr_o && !mem_rdy_i |=> bus_wr_o && $stable(bus_addr_o) && $stable(internal_data_lines_o);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write cycle dropped early"); // RULE6

    property p_wr_hi;
        @(posedge mclk_i) disable iff (!reset_n_i)
        bus_wr_o && half_r |-> bus_addr_o == dar_r + 24'h00_0002 &&
            internal_data_lines_o == dbuf_r[31:16];
    endproperty
    a_wr_hi: assert property (p_wr_hi) else $error("upper half write bad"); // RULE8

    property p_rd_fill;
        @(posedge mclk_i) disable iff (!reset_n_i)
        bus_rd_o && mem_rdy_i && size_r == `BIU_SZ_WORD |=>
            dbuf_r[15:0] == $past(internal_data_lines_i) && dbuf_r[31:16] == 16'h0000;
    endproperty
    a_rd_fill: assert property (p_rd_fill) else $error("word read not buffered"); // RULE2

    property p_code_fill;
        @(posedge mclk_i) disable iff (!reset_n_i)
        bus_code_sel_o && mem_rdy_i |=> rsp_valid_o && rsp_data_o == $past(code_bus_i);
    endproperty
    a_code_fill: assert property (p_code_fill) else $error("code bus read bad"); // RULE11

    property p_dword_hi;
        @(posedge mclk_i) disable iff (!reset_n_i)
        bus_rd_o && mem_rdy_i && half_r |=>
            rsp_valid_o && rsp_data_o[31:16] == $past(internal_data_lines_i);
    endproperty
    a_dword_hi: assert property (p_dword_hi) else $error("upper half read bad"); // RULE10

    property p_rsp_one;
        @(posedge mclk_i) disable iff (!reset_n_i)
        rsp_valid_o |=> !rsp_valid_o && req_ready_o;
    endproperty
    a_rsp_one: assert property (p_rsp_one) else $error("answer not single"); // RULE3

    property p_ready_idle;
        @(posedge mclk_i) disable iff (!reset_n_i)
        req_ready_o |-> !bus_rd_o && !bus_wr_o && !rsp_valid_o;
    endproperty
    a_ready_idle: assert property (p_ready_idle) else $error("ready during transfer"); // RULE4
endmodule : biu_data_path

// file: test/biu_mem_model.sv
// Purpose: internal memory / peripheral side of the data access path
// Assumes: strobes held until ready; zero or three wait cycles
// Notes:   data lines show inverted pattern outside the ready cycle
`timescale 1ns/1ps
module biu_mem_model (
    input  wire logic        mclk_i,
    input  wire logic        rd_i,
    input  wire logic        wr_i,
    input  wire logic        mem_sel_i,
    input  wire logic        slow_i,
    input  wire logic [23:0] addr_i,
    input  wire logic [15:0] wdat_i,
    output logic             rdy_o,
    output logic [15:0]      dat_o,
    output logic [31:0]      code_o,
    output logic [23:0]      wa_o,
    output logic [15:0]      wd_o
);
    logic [1:0] wait_r = 2'h0;
    function automatic logic [15:0] pat(input logic [23:0] a);
        return a[15:0] ^ 16'ha5c3;
    endfunction : pat
    // ready after a short or long wait
    assign rdy_o = (rd_i | wr_i) && (wait_r == (slow_i ? 2'h3 : 2'h0));
    always_ff @(posedge mclk_i) begin
        wait_r <= (rdy_o || !(rd_i | wr_i)) ? 2'h0 : wait_r + 2'h1;
    end
    // code bus answered only by memory
    assign dat_o  = rdy_o ? pat(addr_i) : ~pat(addr_i);
    assign code_o = (rdy_o && mem_sel_i) ? {pat(addr_i + 24'h2), pat(addr_i)}
                                         : ~{pat(addr_i + 24'h2), pat(addr_i)};
    // last write beat seen
    always_ff @(posedge mclk_i) begin
        if (rdy_o && wr_i) begin
            wa_o <= addr_i;
            wd_o <= wdat_i;
        end
    end
endmodule : biu_mem_model

// file: test/tb_biu_data_access_path.sv
// Purpose: self-checking bench for the data access path
// Assumes: memory model on the internal bus side
// Notes:   expected results queued by the driver, popped on rsp_valid_o
`timescale 1ns/1ps
`include "biu_consts.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_biu_data_access_path;
    logic mclk_i = 0, reset_n_i = 0, req_valid_i = 0, mem_sel_i = 0, slow = 0;
    logic rdy, req_ready_o, rsp_valid_o, bus_rd_o, bus_wr_o;
    logic [23:0] pf_addr_i = 24'h0, bus_addr_o, wa;
    logic [15:0] dl_o, dl_i, wd;
    logic [31:0] rsp_data_o, code;
    logic [56:0] x;
    logic [56:0] expq[$];
    logic [1:0]  lane, cur_sz = 2'h0;
    logic        csel, cur_wr = 1'b0;
    logic [2:0]  pe;
    int          beats = 0;
    biu_pkg::biu_req_t   req_i = '0;
    biu_pkg::biu_align_t pf_class_o;
    int miscompares = 0, n_tests = 0;
    always #2.5 mclk_i = ~mclk_i;
    biu_data_path DUT (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .req_valid_i(req_valid_i),
        .req_i(req_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
        .rsp_data_o(rsp_data_o), .bus_addr_o(bus_addr_o), .bus_rd_o(bus_rd_o),
        .bus_wr_o(bus_wr_o), .bus_lane_o(lane), .bus_code_sel_o(csel),
        .internal_data_lines_o(dl_o),
        .internal_data_lines_i(dl_i), .code_bus_i(code), .mem_sel_i(mem_sel_i),
        .mem_rdy_i(rdy), .pf_addr_i(pf_addr_i), .pf_class_o(pf_class_o));
    biu_mem_model MDL (.mclk_i(mclk_i), .rd_i(bus_rd_o), .wr_i(bus_wr_o), .mem_sel_i(mem_sel_i),
        .slow_i(slow), .addr_i(bus_addr_o), .wdat_i(dl_o), .rdy_o(rdy), .dat_o(dl_i),
        .code_o(code), .wa_o(wa), .wd_o(wd));
    task give_verdict;
        $display("errors %0d of %0d checks", miscompares, n_tests);
        if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    // one request; expectation noted before the take
    task xfer(input logic wr, input logic [1:0] sz, input logic [23:0] a, input logic [31:0] d);
        int k;
        logic [15:0] p, q;
        logic [31:0] e;
        k = 0;
        while (!req_ready_o && k < 60) begin @(posedge mclk_i); #1; k++; end
        if (k == 60) begin miscompares++; give_verdict; end
        p = a[15:0] ^ 16'ha5c3;
        q = (a[15:0] + 16'h2) ^ 16'ha5c3;
        case (sz)
            2'h0: e = wr ? {24'h0, d[7:0]} : {24'h0, p[7:0]};
            2'h1: e = wr ? {16'h0, d[15:0]} : {16'h0, p};
            default: e = wr ? {16'h0, d[31:16]} : {q, p};
        endcase
        expq.push_back({wr, (sz == 2'h2) ? a + 24'h2 : a, e});
        mem_sel_i = 1'($urandom);
        slow = 1'($urandom);
        cur_sz = sz;
        cur_wr = wr;
        req_i = '{wr: wr, size: sz, addr: a, wdata: d};
        req_valid_i = 1;
        @(posedge mclk_i);
        #1 req_valid_i = 0;
    endtask : xfer
    // result watcher; bus beats checked for lane use and pairing
    always @(posedge mclk_i) begin
        if ((bus_rd_o || bus_wr_o) && rdy) begin
            beats++;
            `CHK(lane, (cur_sz == `BIU_SZ_BYTE) ? 2'h1 : 2'h3)
            `CHK(csel, !cur_wr && mem_sel_i && cur_sz == `BIU_SZ_DWORD)
        end
        if (rsp_valid_o) begin
            `CHK(beats, (cur_sz == `BIU_SZ_DWORD && (cur_wr || !mem_sel_i)) ? 2 : 1)
            beats = 0;
            if (expq.size() == 0) miscompares++;
            else begin
                x = expq.pop_front();
                if (x[56]) `CHK({wa, 16'h0, wd}, x[55:0])
                else `CHK(rsp_data_o, x[31:0])
            end
        end
    end
    initial begin
        void'($urandom(32'hdd47));
        repeat (5) @(posedge mclk_i);
        #1 reset_n_i = 1;
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk_i);
            #1 pf_addr_i = (i < 2) ? 24'(i * 8) : 24'($urandom);
            pe[2] = (pf_addr_i % 24'h00_0002) == 24'h00_0000;
            pe[1] = (pf_addr_i % 24'h00_0004) == 24'h00_0000;
            pe[0] = (pf_addr_i % 24'h00_0008) == 24'h00_0000;
            #1 `CHK(pf_class_o, pe)
        end
        @(posedge mclk_i);
        #1;
        for (int i = 0; i < 48; i++) xfer(i[0], 2'((i >> 1) % 3), 24'($urandom) & 24'hff_fffe,
            $urandom);
        for (int k = 0; k < 100 && expq.size() != 0; k++) @(posedge mclk_i);
        if (expq.size() != 0) miscompares++;
        give_verdict;
    end
endmodule : tb_biu_data_access_path
